// File: verilog/dccr_pkg.sv
/*
 * constants shared by the channel configuration register bank:
 * register addresses, bus page and command codes, field positions,
 * writable-bit masks, reset values and decode enumerations.
 * assumes nothing of its surroundings.
 */
package dccr_pkg;

   localparam int          DCCR_NCH        = 2;
   localparam int          DCCR_CODE_BITS  = 12;

   // direct register addresses, channel 0 and channel 1
   localparam logic [7:0]  ADDR_MLOW_CH0   = 8'h14;
   localparam logic [7:0]  ADDR_VCMP_CH0   = 8'h15;
   localparam logic [7:0]  ADDR_ICFG_CH0   = 8'h16;
   localparam logic [7:0]  ADDR_MLOW_CH1   = 8'h02;
   localparam logic [7:0]  ADDR_VCMP_CH1   = 8'h03;
   localparam logic [7:0]  ADDR_ICFG_CH1   = 8'h04;

   // paged bus access
   localparam logic [7:0]  PAGE_CFG        = 8'hFF;
   localparam logic [7:0]  PAGE_MLOW_CH0   = 8'h03;
   localparam logic [7:0]  PAGE_MLOW_CH1   = 8'h00;
   localparam logic [7:0]  CMD_MLOW        = 8'h26;
   localparam logic [7:0]  CMD_VCMP_CH0    = 8'hDD;
   localparam logic [7:0]  CMD_VCMP_CH1    = 8'hD1;
   localparam logic [7:0]  CMD_ICFG_CH0    = 8'hDE;
   localparam logic [7:0]  CMD_ICFG_CH1    = 8'hD2;

   localparam logic [15:0] REG_RESET       = 16'h0000;

   // field positions
   localparam int          GAIN_LSB        = 10;
   localparam int          GAIN_MSB        = 12;
   localparam int          OD_BIT          = 4;
   localparam int          ROUTE_BIT       = 3;
   localparam int          FBDIV_BIT       = 2;
   localparam int          POL_BIT         = 1;
   localparam int          CMPEN_BIT       = 0;
   localparam int          SPAN_LSB        = 9;
   localparam int          SPAN_MSB        = 12;
   localparam int          MARGIN_LSB      = 4;

   // writable bits; everything else stores zero
   localparam logic [15:0] VCMP_MASK       = 16'h1C1F;
   localparam logic [15:0] ICFG_MASK       = 16'h1E00;
   localparam logic [15:0] MLOW_MASK_12B   = 16'hFFF0;
   localparam logic [15:0] MLOW_MASK_10B   = 16'hFFC0;

   localparam logic [2:0]  GAIN_MAX_VALID  = 3'h5;
   localparam logic [3:0]  SPAN_SINK_FIRST = 4'h4;
   localparam logic [3:0]  SPAN_BIP_FIRST  = 4'h8;
   localparam logic [3:0]  SPAN_MAX_VALID  = 4'hB;

   typedef enum logic [1:0] {
      DCCR_SEL_VCMP,
      DCCR_SEL_ICFG,
      DCCR_SEL_MLOW,
      DCCR_SEL_NONE
   } dccr_sel_t;

   typedef enum logic [1:0] {
      DCCR_SPAN_SOURCE,
      DCCR_SPAN_SINK,
      DCCR_SPAN_BIPOLAR,
      DCCR_SPAN_INVALID
   } dccr_span_kind_t;

endpackage

// File: verilog/dccr_cfg_if.sv
/*
 * carrier between the register decode and one channel's storage:
 * write strobes with data one way, stored register values back.
 * assumes one clock shared by both ends.
 */
`timescale 1ns/1ps
interface dccr_cfg_if;
   logic        wr_vcmp;
   logic        wr_icfg;
   logic        wr_mlow;
   logic [15:0] wdata;
   logic [15:0] vcmp_q;
   logic [15:0] icfg_q;
   logic [15:0] mlow_q;

   modport ctrl (output wr_vcmp, wr_icfg, wr_mlow, wdata,
                 input  vcmp_q, icfg_q, mlow_q);
   modport chan (input  wr_vcmp, wr_icfg, wr_mlow, wdata,
                 output vcmp_q, icfg_q, mlow_q);
endinterface

// File: verilog/dccr_channel.sv
/*
 * one channel: margin-low, voltage/comparator and current-span setup
 * registers plus the registered control outputs they decode to.
 * assumes write strobes arrive already decoded and synchronous.
 */
`timescale 1ns/1ps
module dccr_channel
   import dccr_pkg::*;
#(
   parameter logic [15:0] MLOW_MASK = MLOW_MASK_12B
) (
   input  wire logic        mclk,
   input  wire logic        rst_n,
   dccr_cfg_if.chan         cfg,
   input  wire logic        cmp_raw,
   input  wire logic        iout_powered,
   input  wire logic        vout_enabled,
   output logic             pin_out_reg,
   output logic             pin_oe_n_reg,
   output logic             cmp_result_reg,
   output logic             fb_divider_reg,
   output logic [2:0]       gain_sel_reg,
   output logic             gain_invalid_reg,
   output logic [3:0]       span_sel_reg,
   output logic [1:0]       span_kind_reg,
   output logic             setup_conflict_reg,
   output logic [11:0]      margin_low_reg
);
   logic [15:0] vcmp_reg;
   logic [15:0] icfg_reg;
   logic [15:0] mlow_reg;
   logic        cmp_on;
   logic        route_on;
   logic        cmp_next;
   logic [3:0]  span;

   assign cfg.vcmp_q = vcmp_reg;
   assign cfg.icfg_q = icfg_reg;
   assign cfg.mlow_q = mlow_reg;

   // don't-care positions never store, so they read back zero
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         vcmp_reg <= REG_RESET;
         icfg_reg <= REG_RESET;
         mlow_reg <= REG_RESET;
      end else begin
         if (cfg.wr_vcmp) begin
            vcmp_reg <= cfg.wdata & VCMP_MASK; // R16
         end
         if (cfg.wr_icfg) begin
            icfg_reg <= cfg.wdata & ICFG_MASK; // R16
         end
         if (cfg.wr_mlow) begin
            mlow_reg <= cfg.wdata & MLOW_MASK; // R02
         end
      end
   end

   assign cmp_on   = vcmp_reg[CMPEN_BIT]; // R10
   assign route_on = cmp_on & vcmp_reg[ROUTE_BIT];
   assign cmp_next = cmp_raw ^ vcmp_reg[POL_BIT]; // R09
   assign span     = icfg_reg[SPAN_MSB:SPAN_LSB];

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pin_out_reg    <= 1'b0;
         pin_oe_n_reg   <= 1'b1;
         cmp_result_reg <= 1'b0;
      end else begin
         cmp_result_reg <= cmp_next;
         if (!route_on) begin
            // result stays internal; the analog output owns the pin
            pin_out_reg  <= 1'b0; // R07
            pin_oe_n_reg <= 1'b1;
         end else if (vcmp_reg[OD_BIT]) begin
            // open drain: only ever pull low, release for a one
            pin_out_reg  <= 1'b0; // R06
            pin_oe_n_reg <= cmp_next;
         end else begin
            pin_out_reg  <= cmp_next; // R06
            pin_oe_n_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         fb_divider_reg   <= 1'b0;
         gain_sel_reg     <= 3'h0;
         gain_invalid_reg <= 1'b0;
      end else begin
         fb_divider_reg   <= vcmp_reg[FBDIV_BIT]; // R08
         gain_sel_reg     <= vcmp_reg[GAIN_MSB:GAIN_LSB]; // R05
         gain_invalid_reg <= vcmp_reg[GAIN_MSB:GAIN_LSB] > GAIN_MAX_VALID;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         span_sel_reg  <= 4'h0;
         span_kind_reg <= DCCR_SPAN_SOURCE;
      end else begin
         span_sel_reg <= span; // R13
         if (span > SPAN_MAX_VALID) begin
            span_kind_reg <= DCCR_SPAN_INVALID; // R15
         end else if (span >= SPAN_BIP_FIRST) begin
            span_kind_reg <= DCCR_SPAN_BIPOLAR; // R15
         end else if (span >= SPAN_SINK_FIRST) begin
            span_kind_reg <= DCCR_SPAN_SINK; // R14
         end else begin
            span_kind_reg <= DCCR_SPAN_SOURCE; // R13
         end
      end
   end

   // flags software enabling the comparator with the wrong output setup
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         setup_conflict_reg <= 1'b0;
         margin_low_reg     <= 12'h000;
      end else begin
         setup_conflict_reg <= cmp_on & (iout_powered | ~vout_enabled); // R10
         margin_low_reg     <= mlow_reg[15:MARGIN_LSB]; // R01
      end
   end
endmodule

// File: verilog/dccr_top.sv
/*
 * per-channel configuration register bank of a dual output converter:
 * margin-low code, voltage gain and comparator setup, current span.
 * assumes the serial interface logic hands over decoded accesses,
 * synchronous to mclk, either by direct address or by page+command.
 */
// Notes on behaviour
// R01: margin-low code is straight binary, left aligned, MSB at bit 15.
// R02: ten-bit variant keeps ten code bits; two below and low four ignored.
// R03: voltage setup at 15h for channel 0, 03h for channel 1, reset zero.
// R04: voltage setup also at page FFh, commands DDh and D1h.
// R05: gain code 000..101 selects reference and gain; others invalid.
// R06: open-drain select makes pin open drain when comparator drives it.
// R07: routing bit keeps comparator internal or drives it onto the pin.
// R08: bit 2 connects the feedback divider; zero leaves input high-Z.
// R09: polarity bit inverts the comparator result before any use.
// R10: bit 0 enables comparator; software needs current off, voltage on.
// R11: current setup at 16h for channel 0, 04h for channel 1, reset zero.
// R12: current setup also at page FFh, commands DEh and D2h.
// R13: span codes 0000..0011 select sourcing spans.
// R14: span codes 0100..0111 select sinking spans.
// R15: span codes 1000..1011 bipolar; remaining codes invalid.
// R16: don't-care bits ignore writes and read back zero.
`timescale 1ns/1ps
module dccr_top
   import dccr_pkg::*;
#(
   parameter int CODE_BITS = DCCR_CODE_BITS
) (
   input  wire logic                         mclk,
   input  wire logic                         rst_n,
   input  wire logic                         reg_wr_en,
   input  wire logic                         reg_rd_en,
   input  wire logic                         reg_paged,
   input  wire logic [7:0]                   reg_page,
   input  wire logic [7:0]                   reg_addr,
   input  wire logic [15:0]                  reg_wdata,
   output logic      [15:0]                  reg_rdata,
   output logic                              reg_rd_valid,
   output logic                              reg_addr_err,
   input  wire logic [DCCR_NCH-1:0]          cmp_raw,
   input  wire logic [DCCR_NCH-1:0]          iout_powered,
   input  wire logic [DCCR_NCH-1:0]          vout_enabled,
   output logic      [DCCR_NCH-1:0]          channel_output_pin_out,
   output logic      [DCCR_NCH-1:0]          channel_output_pin_oe_n,
   output logic      [DCCR_NCH-1:0]          comparator_result,
   output logic      [DCCR_NCH-1:0]          feedback_divider_connect,
   output logic      [DCCR_NCH-1:0][2:0]     output_gain_select,
   output logic      [DCCR_NCH-1:0]          gain_code_invalid,
   output logic      [DCCR_NCH-1:0][3:0]     current_span_select,
   output logic      [DCCR_NCH-1:0][1:0]     current_span_kind,
   output logic      [DCCR_NCH-1:0]          comparator_setup_conflict,
   output logic      [DCCR_NCH-1:0][11:0]    lower_margin_code
);
   localparam logic [15:0] MLOW_MASK =
      (CODE_BITS == 10) ? MLOW_MASK_10B : MLOW_MASK_12B;

   dccr_sel_t      sel;
   logic           sel_ch;
   logic [15:0]    rd_mux;
   logic [15:0]    reg_rdata_reg;
   logic           reg_rd_valid_reg;
   logic           reg_addr_err_reg;
   logic [15:0]    vcmp_q [DCCR_NCH];
   logic [15:0]    icfg_q [DCCR_NCH];
   logic [15:0]    mlow_q [DCCR_NCH];

   // both access paths land on the same storage
   always_comb begin
      sel    = DCCR_SEL_NONE;
      sel_ch = 1'b0;
      if (reg_paged) begin
         if (reg_page == PAGE_CFG) begin
            case (reg_addr)
               CMD_VCMP_CH0: begin
                  sel = DCCR_SEL_VCMP; // R04
               end
               CMD_VCMP_CH1: begin
                  sel    = DCCR_SEL_VCMP; // R04
                  sel_ch = 1'b1;
               end
               CMD_ICFG_CH0: begin
                  sel = DCCR_SEL_ICFG; // R12
               end
               CMD_ICFG_CH1: begin
                  sel    = DCCR_SEL_ICFG; // R12
                  sel_ch = 1'b1;
               end
               default: begin
                  sel = DCCR_SEL_NONE;
               end
            endcase
         end else if (reg_addr == CMD_MLOW) begin
            if (reg_page == PAGE_MLOW_CH0) begin
               sel = DCCR_SEL_MLOW;
            end else if (reg_page == PAGE_MLOW_CH1) begin
               sel    = DCCR_SEL_MLOW;
               sel_ch = 1'b1;
            end
         end
      end else begin
         case (reg_addr)
            ADDR_VCMP_CH0: begin
               sel = DCCR_SEL_VCMP; // R03
            end
            ADDR_VCMP_CH1: begin
               sel    = DCCR_SEL_VCMP; // R03
               sel_ch = 1'b1;
            end
            ADDR_ICFG_CH0: begin
               sel = DCCR_SEL_ICFG; // R11
            end
            ADDR_ICFG_CH1: begin
               sel    = DCCR_SEL_ICFG; // R11
               sel_ch = 1'b1;
            end
            ADDR_MLOW_CH0: begin
               sel = DCCR_SEL_MLOW;
            end
            ADDR_MLOW_CH1: begin
               sel    = DCCR_SEL_MLOW;
               sel_ch = 1'b1;
            end
            default: begin
               sel = DCCR_SEL_NONE;
            end
         endcase
      end
   end

   genvar g;
   generate
      for (g = 0; g < DCCR_NCH; g++) begin : g_ch
         dccr_cfg_if cfg ();
         logic hit;

         assign hit             = reg_wr_en & (sel_ch == 1'(g));
         assign cfg.wr_vcmp     = hit & (sel == DCCR_SEL_VCMP);
         assign cfg.wr_icfg     = hit & (sel == DCCR_SEL_ICFG);
         assign cfg.wr_mlow     = hit & (sel == DCCR_SEL_MLOW);
         assign cfg.wdata       = reg_wdata;
         assign vcmp_q[g]       = cfg.vcmp_q;
         assign icfg_q[g]       = cfg.icfg_q;
         assign mlow_q[g]       = cfg.mlow_q;

         dccr_channel #(
            .MLOW_MASK (MLOW_MASK)
         ) u_ch (
            .mclk               (mclk),
            .rst_n              (rst_n),
            .cfg                (cfg.chan),
            .cmp_raw            (cmp_raw[g]),
            .iout_powered       (iout_powered[g]),
            .vout_enabled       (vout_enabled[g]),
            .pin_out_reg        (channel_output_pin_out[g]),
            .pin_oe_n_reg       (channel_output_pin_oe_n[g]),
            .cmp_result_reg     (comparator_result[g]),
            .fb_divider_reg     (feedback_divider_connect[g]),
            .gain_sel_reg       (output_gain_select[g]),
            .gain_invalid_reg   (gain_code_invalid[g]),
            .span_sel_reg       (current_span_select[g]),
            .span_kind_reg      (current_span_kind[g]),
            .setup_conflict_reg (comparator_setup_conflict[g]),
            .margin_low_reg     (lower_margin_code[g])
         );
      end
   endgenerate

   always_comb begin
      case (sel)
         DCCR_SEL_VCMP: rd_mux = vcmp_q[sel_ch];
         DCCR_SEL_ICFG: rd_mux = icfg_q[sel_ch];
         DCCR_SEL_MLOW: rd_mux = mlow_q[sel_ch];
         default:       rd_mux = 16'h0000;
      endcase
   end

   // an unmapped read answers zero with the error pulse, so the
   // interface logic never waits on a missing answer
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata_reg    <= 16'h0000;
         reg_rd_valid_reg <= 1'b0;
         reg_addr_err_reg <= 1'b0;
      end else begin
         reg_rd_valid_reg <= reg_rd_en;
         reg_addr_err_reg <= (reg_rd_en | reg_wr_en) &
                             (sel == DCCR_SEL_NONE);
         if (reg_rd_en) begin
            reg_rdata_reg <= rd_mux; // R16
         end
      end
   end

   assign reg_rdata    = reg_rdata_reg;
   assign reg_rd_valid = reg_rd_valid_reg;
   assign reg_addr_err = reg_addr_err_reg;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   sequence s_wr_vcmp0_direct;
      reg_wr_en && !reg_paged && reg_addr == ADDR_VCMP_CH0;
   endsequence

   sequence s_wr_vcmp1_paged;
      reg_wr_en && reg_paged && reg_page == PAGE_CFG &&
      reg_addr == CMD_VCMP_CH1;
   endsequence

   sequence s_rd_icfg0;
      reg_rd_en && !reg_wr_en && !reg_paged && reg_addr == ADDR_ICFG_CH0;
   endsequence

   a_vcmp_direct_wr: assert property ( // R03
      s_wr_vcmp0_direct |=> vcmp_q[0] == ($past(reg_wdata) & VCMP_MASK))
      else $error("voltage setup ch0 write not stored");

   a_vcmp_paged_wr: assert property ( // R04
      s_wr_vcmp1_paged |=> vcmp_q[1] == ($past(reg_wdata) & VCMP_MASK))
      else $error("paged voltage setup ch1 write not stored");

   a_icfg_read_back: assert property ( // R11
      s_rd_icfg0 ##1 reg_rd_valid |-> reg_rdata == $past(icfg_q[0]))
      else $error("current setup ch0 read mismatch");

   a_icfg_paged_wr: assert property ( // R12
      reg_wr_en && reg_paged && reg_page == PAGE_CFG &&
      reg_addr == CMD_ICFG_CH0
      |=> icfg_q[0] == ($past(reg_wdata) & ICFG_MASK))
      else $error("paged current setup ch0 write not stored");

   a_margin_dont_care: assert property ( // R02
      (mlow_q[0] & ~MLOW_MASK) == 16'h0000 &&
      lower_margin_code[0] == $past(mlow_q[0][15:MARGIN_LSB]))
      else $error("margin-low don't-care bits hold data");

   a_gain_valid_flag: assert property ( // R05
      ##1 gain_code_invalid[1] ==
          ($past(vcmp_q[1][GAIN_MSB:GAIN_LSB]) > GAIN_MAX_VALID))
      else $error("gain invalid flag wrong");

   a_open_drain_pin: assert property ( // R06
      $past(vcmp_q[0][CMPEN_BIT] & vcmp_q[0][ROUTE_BIT] &
            vcmp_q[0][OD_BIT])
      |-> channel_output_pin_out[0] == 1'b0 &&
          channel_output_pin_oe_n[0] == comparator_result[0])
      else $error("open-drain pin drove high");

   a_route_internal: assert property ( // R07
      !$past(vcmp_q[1][CMPEN_BIT] & vcmp_q[1][ROUTE_BIT])
      |-> channel_output_pin_oe_n[1])
      else $error("pin driven while comparator internal");

   a_cmp_polarity: assert property ( // R09
      ##1 comparator_result[0] ==
          ($past(cmp_raw[0]) ^ $past(vcmp_q[0][POL_BIT])))
      else $error("comparator polarity wrong");

   a_span_bipolar: assert property ( // R15
      $past(icfg_q[0][SPAN_MSB:SPAN_LSB]) inside {[4'h8:4'hB]}
      |-> current_span_kind[0] == DCCR_SPAN_BIPOLAR)
      else $error("bipolar span not decoded");

   a_cmp_conflict: assert property ( // R10
      vcmp_q[1][CMPEN_BIT] && !vout_enabled[1]
      |=> comparator_setup_conflict[1])
      else $error("comparator setup conflict missed");

   a_unmapped_read: assert property ( // R16
      reg_rd_en && sel == DCCR_SEL_NONE
      |=> reg_addr_err && reg_rd_valid && reg_rdata == 16'h0000)
      else $error("unmapped read not answered with zero");

   a_span_source: assert property ( // R13
      $past(icfg_q[0][SPAN_MSB:SPAN_LSB]) < SPAN_SINK_FIRST
      |-> current_span_kind[0] == DCCR_SPAN_SOURCE)
      else $error("sourcing span not decoded");

   a_span_sink: assert property ( // R14
      $past(icfg_q[0][SPAN_MSB:SPAN_LSB]) inside {[4'h4:4'h7]}
      |-> current_span_kind[0] == DCCR_SPAN_SINK)
      else $error("sinking span not decoded");

   a_span_invalid: assert property ( // R15
      $past(icfg_q[0][SPAN_MSB:SPAN_LSB]) > SPAN_MAX_VALID
      |-> current_span_kind[0] == DCCR_SPAN_INVALID)
      else $error("invalid span not flagged");

   a_fb_divider: assert property ( // R08
      ##1 feedback_divider_connect[1] == $past(vcmp_q[1][FBDIV_BIT]))
      else $error("feedback divider select wrong");

   a_gain_select: assert property ( // R05
      ##1 output_gain_select[1] == $past(vcmp_q[1][GAIN_MSB:GAIN_LSB]))
      else $error("gain select wrong");

   a_push_pull_pin: assert property ( // R06
      $past(vcmp_q[1][CMPEN_BIT] & vcmp_q[1][ROUTE_BIT] &
            !vcmp_q[1][OD_BIT])
      |-> !channel_output_pin_oe_n[1] &&
          channel_output_pin_out[1] == comparator_result[1])
      else $error("push-pull pin not driven");

endmodule

// File: verif/dccr_host_model.sv
/*
 * host side of the channel configuration register port: issues one
 * access at a time and returns what the bank answers.
 * assumes a single rising-edge clock shared with the register bank.
 */
`timescale 1ns/1ps
module dccr_host_model (
   input  wire logic        mclk,
   input  wire logic [15:0] reg_rdata,
   input  wire logic        reg_rd_valid,
   input  wire logic        reg_addr_err,
   output logic             reg_wr_en,
   output logic             reg_rd_en,
   output logic             reg_paged,
   output logic [7:0]       reg_page,
   output logic [7:0]       reg_addr,
   output logic [15:0]      reg_wdata
);
   initial begin
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_paged = 1'b0;
      reg_page  = 8'h00;
      reg_addr  = 8'h00;
      reg_wdata = 16'h0000;
   end

   // fields flip after the taking edge, so stale ones never pass as new
   task automatic access(input  logic        wr,
                         input  logic        paged,
                         input  logic [7:0]  page,
                         input  logic [7:0]  addr,
                         input  logic [15:0] wdata,
                         output logic [15:0] rdata,
                         output logic        err,
                         output logic        ok);
      @(posedge mclk);
      reg_wr_en <= wr;
      reg_rd_en <= !wr;
      reg_paged <= paged;
      reg_page  <= page;
      reg_addr  <= addr;
      reg_wdata <= wdata;
      @(posedge mclk);
      reg_wr_en <= 1'b0;
      reg_rd_en <= 1'b0;
      reg_page  <= ~page;
      reg_addr  <= ~addr;
      reg_wdata <= ~wdata;
      @(negedge mclk);
      rdata = reg_rdata;
      err   = (reg_addr_err === 1'b1);
      ok    = wr || (reg_rd_valid === 1'b1);
   endtask
endmodule

// File: verif/tb_top.sv
/*
 * self-checking bench for the channel configuration register bank.
 * assumes the host model drives the register port and this module
 * drives the comparator and output-state inputs.
 */
`timescale 1ns/1ps
module tb_top;
   import dccr_pkg::*;
   logic             mclk;
   logic             rst_n;
   logic             wr_en, rd_en, paged, rd_valid, addr_err;
   logic [7:0]       page, addr;
   logic [15:0]      wdata, rdata;
   logic [1:0]       cmp_raw, iout_powered, vout_enabled;
   logic [1:0]       pin_out, pin_oe_n, cmp_res, fb_div, gain_inv, conflict;
   logic [1:0][2:0]  gain;
   logic [1:0][3:0]  span;
   logic [1:0][1:0]  kind;
   logic [1:0][11:0] margin, margin10;
   int               errors;
   int               checks_done;
   logic [7:0]       da [6] = '{8'h14, 8'h15, 8'h16, 8'h02, 8'h03, 8'h04};
   logic [7:0]       pg [6] = '{8'h03, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'hFF};
   logic [7:0]       cm [6] = '{8'h26, 8'hDD, 8'hDE, 8'h26, 8'hD1, 8'hD2};
   logic [15:0]      mk [6] = '{16'hFFF0, 16'h1C1F, 16'h1E00,
                                16'hFFF0, 16'h1C1F, 16'h1E00};

   always #10 mclk = ~mclk;

   dccr_host_model host (
      .mclk(mclk), .reg_rdata(rdata), .reg_rd_valid(rd_valid),
      .reg_addr_err(addr_err), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
      .reg_paged(paged), .reg_page(page), .reg_addr(addr),
      .reg_wdata(wdata));

   dccr_top uut (
      .mclk(mclk), .rst_n(rst_n), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
      .reg_paged(paged), .reg_page(page), .reg_addr(addr),
      .reg_wdata(wdata), .reg_rdata(rdata), .reg_rd_valid(rd_valid),
      .reg_addr_err(addr_err), .cmp_raw(cmp_raw),
      .iout_powered(iout_powered), .vout_enabled(vout_enabled),
      .channel_output_pin_out(pin_out),
      .channel_output_pin_oe_n(pin_oe_n), .comparator_result(cmp_res),
      .feedback_divider_connect(fb_div), .output_gain_select(gain),
      .gain_code_invalid(gain_inv), .current_span_select(span),
      .current_span_kind(kind), .comparator_setup_conflict(conflict),
      .lower_margin_code(margin));

   dccr_top #(.CODE_BITS(10)) uut_ten (
      .mclk(mclk), .rst_n(rst_n), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
      .reg_paged(paged), .reg_page(page), .reg_addr(addr),
      .reg_wdata(wdata), .reg_rdata(), .reg_rd_valid(),
      .reg_addr_err(), .cmp_raw(cmp_raw),
      .iout_powered(iout_powered), .vout_enabled(vout_enabled),
      .channel_output_pin_out(), .channel_output_pin_oe_n(),
      .comparator_result(), .feedback_divider_connect(),
      .output_gain_select(), .gain_code_invalid(),
      .current_span_select(), .current_span_kind(),
      .comparator_setup_conflict(), .lower_margin_code(margin10));

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic acc(input  logic        wr,
                      input  logic        pgd,
                      input  logic [7:0]  pv,
                      input  logic [7:0]  a,
                      input  logic [15:0] d,
                      input  logic        exp_err,
                      output logic [15:0] q);
      logic e, ok;
      host.access(wr, pgd, pv, a, d, q, e, ok);
      chk({14'h0, ok, e}, {14'h0, 1'b1, exp_err});
   endtask

   // outputs trail the stored word, so allow a few edges to settle
   task automatic settle;
      repeat (3) @(posedge mclk);
      @(negedge mclk);
   endtask

   task automatic t_reset;
      logic [15:0] q;
      for (int i = 0; i < 6; i++) begin
         acc(1'b0, 1'b0, 8'h00, da[i], 16'h0000, 1'b0, q);
         chk(q, 16'h0000);
      end
      chk({8'h00, pin_oe_n, pin_out, kind[0], kind[1]}, 16'h00C0);
   endtask

   task automatic t_map;
      logic [15:0] q;
      for (int i = 0; i < 6; i++) begin
         acc(1'b1, 1'b0, 8'h00, da[i], 16'hFFFF, 1'b0, q);
         acc(1'b0, 1'b1, pg[i], cm[i], 16'h0000, 1'b0, q);
         chk(q, mk[i]);
         acc(1'b1, 1'b1, pg[i], cm[i], 16'h0000, 1'b0, q);
         acc(1'b0, 1'b0, 8'h00, da[i], 16'h0000, 1'b0, q);
         chk(q, 16'h0000);
      end
      acc(1'b1, 1'b0, 8'h00, 8'h05, 16'hFFFF, 1'b1, q);
      acc(1'b0, 1'b0, 8'h00, 8'h05, 16'h0000, 1'b1, q);
      chk(q, 16'h0000);
      acc(1'b0, 1'b1, 8'hFF, 8'hD3, 16'h0000, 1'b1, q);
      chk(q, 16'h0000);
   endtask

   task automatic t_margin;
      logic [15:0] q;
      acc(1'b1, 1'b0, 8'h00, 8'h14, 16'hABC5, 1'b0, q);
      acc(1'b1, 1'b0, 8'h00, 8'h02, 16'h123A, 1'b0, q);
      settle;
      chk({4'h0, margin[0]}, 16'h0ABC);
      chk({4'h0, margin[1]}, 16'h0123);
      chk({4'h0, margin10[1]}, 16'h0120);
   endtask

   task automatic t_gain;
      logic [15:0] q;
      for (int g = 0; g < 8; g++) begin
         acc(1'b1, 1'b0, 8'h00, 8'h03, {3'h0, 3'(g), 10'h000}, 1'b0, q);
         settle;
         chk({gain_inv[1], gain[1]}, {(g > 5), 3'(g)});
      end
   endtask

   task automatic t_span;
      logic [15:0] q;
      for (int s = 0; s < 16; s++) begin
         acc(1'b1, 1'b0, 8'h00, 8'h16, {3'h0, 4'(s), 9'h000}, 1'b0, q);
         settle;
         chk({kind[0], span[0]},
             {((s > 11) ? 2'h3 : 2'(s / 4)), 4'(s)});
      end
   endtask

   task automatic t_cmp;
      logic [15:0] q;
      logic        res, on;
      for (int c = 0; c < 2; c++) begin
         for (int v = 0; v < 32; v++) begin
            for (int r = 0; r < 2; r++) begin
               acc(1'b1, 1'b0, 8'h00, (c ? 8'h03 : 8'h15),
                   {11'h000, 5'(v)}, 1'b0, q);
               @(posedge mclk);
               cmp_raw[c] <= r[0];
               settle;
               res = r[0] ^ v[1];
               on  = v[0] & v[3];
               chk({pin_out[c], pin_oe_n[c], cmp_res[c], fb_div[c]},
                   {on & !v[4] & res, !on | (v[4] & res),
                    res, v[2]});
            end
         end
      end
   endtask

   // comparator mode is legal only with current off and voltage on
   task automatic t_conflict;
      logic [15:0] q;
      for (int c = 0; c < 2; c++) begin
         acc(1'b1, 1'b0, 8'h00, (c ? 8'h03 : 8'h15), 16'h0001, 1'b0, q);
         for (int k = 0; k < 4; k++) begin
            @(posedge mclk);
            iout_powered[c] <= k[0];
            vout_enabled[c] <= k[1];
            settle;
            chk({15'h0, conflict[c]}, {15'h0, k[0] | !k[1]});
         end
         acc(1'b1, 1'b0, 8'h00, (c ? 8'h03 : 8'h15), 16'h0000, 1'b0, q);
         @(posedge mclk);
         iout_powered[c] <= 1'b1;
         settle;
         chk({15'h0, conflict[c]}, 16'h0000);
      end
   endtask

   task automatic results;
      if (errors == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   initial begin
      mclk         = 1'b0;
      rst_n        = 1'b0;
      cmp_raw      = 2'b00;
      iout_powered = 2'b00;
      vout_enabled = 2'b11;
      errors       = 0;
      checks_done  = 0;
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      t_reset;
      t_map;
      t_margin;
      t_gain;
      t_span;
      t_cmp;
      t_conflict;
      results;
   end

   initial begin
      repeat (40000) @(posedge mclk);
      errors++;
      $display("[ERR] %0t run did not finish", $time);
      results;
   end
endmodule
